/* File: design/ios_defines.vh */
`ifndef IOS_DEFINES_VH
`define IOS_DEFINES_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define IOS_CTRL_ADDR 8'h00
`define IOS_START_ADDR 8'h04
`define IOS_STATUS_ADDR 8'h08
`define IOS_BANK_ADDR 8'h0C
`define IOS_CTRL_EN_BIT 0
`define IOS_CTRL_RESET 1'h0
`define IOS_BANK_RESET 4'h0

// ----------------------------------------
// Per-device sequence states
// ----------------------------------------
`define IOS_ST_DRT_FETCH 4'h0
`define IOS_ST_CW_FETCH 4'h1
`define IOS_ST_AW_FETCH 4'h2
`define IOS_ST_AW_STORE 4'h3
`define IOS_ST_DRT_STORE 4'h4
`define IOS_ST_DATA 4'h5
`define IOS_ST_HALT 4'h6

// ----------------------------------------
// Order codes, command word bits 15..12
// ----------------------------------------
`define IOS_ORD_JUMP 4'h0
`define IOS_ORD_RETRES 4'h1
`define IOS_ORD_INT 4'h2
`define IOS_ORD_END 4'h3
`define IOS_ORD_CONTROL 4'h4
`define IOS_ORD_SENSE 4'h5
`define IOS_ORD_WRITE 4'h6
`define IOS_ORD_READ 4'h7
`define IOS_ORD_SETBANK 4'h8
`define IOS_JUMP_COND_BIT 11

// ----------------------------------------
// Commands to the I/O processor
// ----------------------------------------
`define IOS_CMD_NONE 3'h0
`define IOS_CMD_DRT_FETCH 3'h1
`define IOS_CMD_FROM_MEM 3'h2
`define IOS_CMD_TO_MEM 3'h3
`define IOS_CMD_DRT_STORE 3'h4
`define IOS_CMD_DONE 3'h5

// ----------------------------------------
// Commands to the device controller
// ----------------------------------------
`define IOS_DC_NONE 4'h0
`define IOS_DC_READ_DEVNO 4'h1
`define IOS_DC_LOAD_CTL 4'h2
`define IOS_DC_SET_IN 4'h3
`define IOS_DC_SET_OUT 4'h4
`define IOS_DC_JUMP_TEST 4'h5
`define IOS_DC_READ_STATUS 4'h6
`define IOS_DC_CLR_REQ 4'h7
`define IOS_DC_LOAD_OUTBUF 4'h8
`define IOS_DC_DRIVE_INBUF 4'h9
`define IOS_DC_SET_INT 4'hA

// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define IOS_PROG_BANK 4'h0
`define IOS_ADDR_STEP 16'h0001
`define IOS_CNT_W 12
`define IOS_CNT_STEP 12'h001
`define IOS_CNT_LAST 12'hFFF

`endif

/* File: design/ios_sequencer.v */
// Functional notes
// - Program entry is two words in bank 0; command word fetched first.
// - Request latch clears on service-out fall, resets next clock if requested.
// - Command-fetch poll loads entry, drives address, service-in, from-memory.
// - Command word goes to order RAM; Control also loads device control.
// - After command fetch, address plus one; next state fetch or store.
// - Read, Write, Jump, Control, Interrupt fetch second word from memory.
// - Fetched address word stored for Read, Write, Jump, Interrupt; Control loads device control.
// - Read sets in-transfer, Write out-transfer; device decides conditional jump.
// - Jump taken or unconditional: next table step is a store, not fetch.
// - Sense, End, Return Residue store second word; address out, to-memory.
// - On that service-out: order for Residue, device status for Sense/End.
// - After second word: End halts, Read/Write data, unconditional Jump table store, others table fetch.
// - Data moves only on device request; address and count advance.
// - Data word: load entry, drive address and bank, service-in, direction.
// - Address step clears device request, increments address and word count.
// - Output: service-out makes device latch word into output buffer.
// - Input: service-out makes device drive its input buffer.
// - After each word working registers are written back to the entry.
// - Count rollover: next data command clears transfer, carries end flag.
// - Restore after final word sets next state to table fetch.
// - Device end after channel service-out starts a table fetch.
// - Sixteen entries: order, address, state, by priority request number.
// - Bank lines zero except while moving Read/Write data.
`timescale 1ns/100ps
`include "ios_defines.vh"

module ios_sequencer #(
	parameter NDEV = 16
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// I/O processor side
	input wire data_poll,
	input wire service_out,
	input wire [15:0] io_data_in,
	output reg channel_service_request,
	output reg poll_out,
	output reg service_in,
	output reg [2:0] io_command_code,
	output reg [15:0] io_data_out,
	output reg io_data_oe_n,
	output reg [3:0] bank_extension_lines,
	// Device controller side
	input wire [NDEV-1:0] service_request,
	input wire device_end,
	input wire jump_met,
	output reg [3:0] dev_command,
	output reg [3:0] dev_select,
	output reg end_of_transfer_flag,
	output reg channel_service_out
);

	// ----------------------------------------
	// Local definitions
	// ----------------------------------------
	localparam P_IDLE = 3'd0;
	localparam P_CSO = 3'd1;
	localparam P_DEVEND = 3'd2;
	localparam P_START = 3'd3;
	localparam P_ADDR = 3'd4;
	localparam P_SO = 3'd5;

	function [3:0] prio;
		input [NDEV-1:0] req;
		integer k;
		begin
			prio = 4'h0;
			for (k = NDEV - 1; k >= 0; k = k - 1) begin
				if (req[k])
					prio = k[3:0];
			end
		end
	endfunction

	function is_store_order;
		input [3:0] ord;
		begin
			is_store_order = (ord == `IOS_ORD_SENSE) ||
				(ord == `IOS_ORD_END) || (ord == `IOS_ORD_RETRES);
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [15:0] order_ram [0:NDEV-1];
	reg [15:0] addr_ram [0:NDEV-1];
	reg [3:0] state_ram [0:NDEV-1];
	reg [3:0] aux_ram [0:NDEV-1];

	reg [2:0] phase_reg;
	reg [3:0] dev_reg;
	reg [3:0] st_reg;
	reg [3:0] next_st_reg;
	reg [15:0] addr_reg;
	reg [15:0] order_reg;
	reg [3:0] aux_reg;
	reg eot_reg;
	reg so_prev_reg;
	reg en_reg;
	reg [3:0] bank_reg;
	reg wr_pend_reg;
	reg [7:0] wr_addr_reg;
	integer i;

	wire so_rise = service_out & ~so_prev_reg;
	wire so_fall = ~service_out & so_prev_reg;
	wire grant = (phase_reg == P_IDLE) && data_poll &&
		channel_service_request;
	wire [3:0] req_num = prio(service_request);
	wire is_rw = (aux_reg == `IOS_ORD_READ) || (aux_reg == `IOS_ORD_WRITE);
	wire cnt_last = (order_reg[`IOS_CNT_W-1:0] == `IOS_CNT_LAST);
	wire [31:0] status_word = {19'h0, eot_reg, st_reg, dev_reg,
		phase_reg, (phase_reg != P_IDLE)};

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
			if (hsel && htrans[1] && hready)
				wr_addr_reg <= haddr[7:0];
			if (hsel && htrans[1] && hready && !hwrite) begin
				case (haddr[7:0])
				`IOS_CTRL_ADDR: hrdata <= {31'h0, en_reg};
				`IOS_STATUS_ADDR: hrdata <= status_word;
				`IOS_BANK_ADDR: hrdata <= {28'h0, bank_reg};
				default: hrdata <= 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Request latch and poll chain
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_service_request <= 1'b0;
			poll_out <= 1'b0;
			so_prev_reg <= 1'b0;
		end else begin
			so_prev_reg <= service_out;
			if (so_fall && phase_reg == P_SO)
				channel_service_request <= 1'b0;
			else if (en_reg && |service_request)
				channel_service_request <= 1'b1;
			poll_out <= data_poll & ~channel_service_request;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (i = 0; i < NDEV; i = i + 1) begin
				order_ram[i] <= 16'h0000;
				addr_ram[i] <= 16'h0000;
				state_ram[i] <= `IOS_ST_HALT;
				aux_ram[i] <= 4'h0;
			end
			phase_reg <= P_IDLE;
			dev_reg <= 4'h0;
			st_reg <= `IOS_ST_HALT;
			next_st_reg <= `IOS_ST_HALT;
			addr_reg <= 16'h0000;
			order_reg <= 16'h0000;
			aux_reg <= 4'h0;
			eot_reg <= 1'b0;
			en_reg <= `IOS_CTRL_RESET;
			bank_reg <= `IOS_BANK_RESET;
			service_in <= 1'b0;
			io_command_code <= `IOS_CMD_NONE;
			io_data_out <= 16'h0000;
			io_data_oe_n <= 1'b1;
			bank_extension_lines <= `IOS_PROG_BANK;
			dev_command <= `IOS_DC_NONE;
			dev_select <= 4'h0;
			end_of_transfer_flag <= 1'b0;
			channel_service_out <= 1'b0;
		end else begin
			channel_service_out <= 1'b0;
			case (phase_reg)
			P_IDLE: begin
				service_in <= 1'b0;
				io_data_oe_n <= 1'b1;
				dev_command <= `IOS_DC_NONE;
				bank_extension_lines <= `IOS_PROG_BANK;
				if (grant) begin
					dev_reg <= req_num;
					dev_select <= req_num;
					st_reg <= state_ram[req_num];
					addr_reg <= addr_ram[req_num];
					order_reg <= order_ram[req_num];
					aux_reg <= aux_ram[req_num];
					if (state_ram[req_num] == `IOS_ST_DATA) begin
						channel_service_out <= 1'b1;
						phase_reg <= P_CSO;
					end else begin
						phase_reg <= P_START;
					end
				end
			end
			P_CSO:
				phase_reg <= P_DEVEND;
			P_DEVEND: begin
				if (device_end)
					st_reg <= `IOS_ST_DRT_FETCH;
				phase_reg <= P_START;
			end
			P_START: begin
				service_in <= 1'b1;
				io_data_out <= addr_reg;
				io_data_oe_n <= 1'b0;
				dev_command <= `IOS_DC_NONE;
				end_of_transfer_flag <= 1'b0;
				phase_reg <= P_ADDR;
				case (st_reg)
				`IOS_ST_DRT_FETCH: begin
					if (jump_met) begin
						io_command_code <= `IOS_CMD_DRT_STORE;
					end else begin
						io_command_code <= `IOS_CMD_DRT_FETCH;
						io_data_oe_n <= 1'b1;
						dev_command <= `IOS_DC_READ_DEVNO;
					end
				end
				`IOS_ST_DRT_STORE:
					io_command_code <= `IOS_CMD_DRT_STORE;
				`IOS_ST_CW_FETCH, `IOS_ST_AW_FETCH:
					io_command_code <= `IOS_CMD_FROM_MEM;
				`IOS_ST_AW_STORE:
					io_command_code <= `IOS_CMD_TO_MEM;
				`IOS_ST_DATA: begin
					io_command_code <= (aux_reg == `IOS_ORD_READ) ?
						`IOS_CMD_TO_MEM : `IOS_CMD_FROM_MEM;
					bank_extension_lines <= is_rw ? bank_reg :
						`IOS_PROG_BANK;
					dev_command <= `IOS_DC_CLR_REQ;
					addr_reg <= addr_reg + `IOS_ADDR_STEP;
					order_reg[`IOS_CNT_W-1:0] <=
						order_reg[`IOS_CNT_W-1:0] + `IOS_CNT_STEP;
					eot_reg <= cnt_last;
				end
				default:
					io_command_code <= `IOS_CMD_DONE;
				endcase
			end
			P_ADDR: begin
				if (so_rise) begin
					phase_reg <= P_SO;
					service_in <= 1'b0;
					io_data_oe_n <= 1'b1;
					dev_command <= `IOS_DC_NONE;
					next_st_reg <= st_reg;
					case (st_reg)
					`IOS_ST_DRT_FETCH: begin
						if (!jump_met)
							addr_reg <= io_data_in;
						next_st_reg <= `IOS_ST_CW_FETCH;
					end
					`IOS_ST_DRT_STORE:
						next_st_reg <= `IOS_ST_CW_FETCH;
					`IOS_ST_CW_FETCH: begin
						order_reg <= io_data_in;
						aux_reg <= io_data_in[15:12];
						if (io_data_in[15:12] == `IOS_ORD_CONTROL)
							dev_command <= `IOS_DC_LOAD_CTL;
						addr_reg <= addr_reg + `IOS_ADDR_STEP;
						next_st_reg <= is_store_order(io_data_in[15:12]) ?
							`IOS_ST_AW_STORE : `IOS_ST_AW_FETCH;
					end
					`IOS_ST_AW_FETCH: begin
						next_st_reg <= `IOS_ST_DRT_FETCH;
						case (aux_reg)
						`IOS_ORD_READ: begin
							addr_reg <= io_data_in;
							dev_command <= `IOS_DC_SET_IN;
							next_st_reg <= `IOS_ST_DATA;
						end
						`IOS_ORD_WRITE: begin
							addr_reg <= io_data_in;
							dev_command <= `IOS_DC_SET_OUT;
							next_st_reg <= `IOS_ST_DATA;
						end
						`IOS_ORD_JUMP: begin
							addr_reg <= io_data_in;
							if (order_reg[`IOS_JUMP_COND_BIT])
								dev_command <= `IOS_DC_JUMP_TEST;
							else
								next_st_reg <= `IOS_ST_DRT_STORE;
						end
						`IOS_ORD_INT: begin
							addr_reg <= io_data_in;
							dev_command <= `IOS_DC_SET_INT;
						end
						`IOS_ORD_CONTROL:
							dev_command <= `IOS_DC_LOAD_CTL;
						default:
							dev_command <= `IOS_DC_NONE;
						endcase
					end
					`IOS_ST_AW_STORE: begin
						if (aux_reg == `IOS_ORD_RETRES) begin
							io_data_out <= order_reg;
							io_data_oe_n <= 1'b0;
						end else begin
							dev_command <= `IOS_DC_READ_STATUS;
						end
						next_st_reg <= (aux_reg == `IOS_ORD_END) ?
							`IOS_ST_HALT : `IOS_ST_DRT_FETCH;
					end
					`IOS_ST_DATA: begin
						dev_command <= (aux_reg == `IOS_ORD_READ) ?
							`IOS_DC_DRIVE_INBUF :
							`IOS_DC_LOAD_OUTBUF;
						end_of_transfer_flag <= eot_reg;
						next_st_reg <= eot_reg ?
							`IOS_ST_DRT_FETCH : `IOS_ST_DATA;
					end
					default:
						next_st_reg <= st_reg;
					endcase
				end
			end
			P_SO: begin
				if (so_fall) begin
					state_ram[dev_reg] <= next_st_reg;
					addr_ram[dev_reg] <= addr_reg;
					order_ram[dev_reg] <= order_reg;
					aux_ram[dev_reg] <= aux_reg;
					service_in <= 1'b0;
					io_data_oe_n <= 1'b1;
					io_command_code <= `IOS_CMD_NONE;
					dev_command <= `IOS_DC_NONE;
					end_of_transfer_flag <= 1'b0;
					bank_extension_lines <= `IOS_PROG_BANK;
					phase_reg <= P_IDLE;
				end else if (st_reg == `IOS_ST_AW_STORE) begin
					// Service-in comes back once the stored word stands
					service_in <= 1'b1;
				end
			end
			default:
				phase_reg <= P_IDLE;
			endcase
			// Register writes from the bus
			if (wr_pend_reg) begin
				case (wr_addr_reg)
				`IOS_CTRL_ADDR: en_reg <= hwdata[`IOS_CTRL_EN_BIT];
				`IOS_START_ADDR:
					state_ram[hwdata[3:0]] <= `IOS_ST_DRT_FETCH;
				`IOS_BANK_ADDR: bank_reg <= hwdata[3:0];
				default: en_reg <= en_reg;
				endcase
			end
		end
	end

endmodule

/* File: tb/ios_far_model.sv */
`timescale 1ns/100ps
module ios_far_model (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// From the channel
	input wire channel_service_request,
	input wire service_in,
	input wire [2:0] io_command_code,
	input wire [15:0] io_data_out,
	input wire [3:0] bank_extension_lines,
	input wire [3:0] dev_command,
	input wire [3:0] dev_select,
	input wire end_of_transfer_flag,
	// To the channel
	output reg data_poll,
	output reg service_out,
	output reg [15:0] io_data_in,
	output reg [15:0] service_request,
	output reg jump_met
);
	reg [15:0] mem [0:1023];
	reg wr [0:1023];
	reg eot_seen, rer, take_jump;
	reg [3:0] rdev, bank_seen;
	integer dones, i;
	initial begin
		data_poll = 1'b0;
		service_out = 1'b0;
		io_data_in = 16'h0000;
		service_request = 16'h0000;
		eot_seen = 1'b0;
		rer = 1'b0;
		jump_met = 1'b0;
		take_jump = 1'b0;
		bank_seen = 4'h0;
		dones = 0;
		for (i = 0; i < 1024; i = i + 1) begin
			mem[i] = 16'h0000;
			wr[i] = 1'b0;
		end
	end
	// Device side: cleared request comes back a cycle later
	always @(posedge hclk) begin
		if (dev_command == 4'h7) begin
			service_request[dev_select] <= 1'b0;
			rer <= 1'b1;
			rdev <= dev_select;
		end else if (rer) begin
			service_request[rdev] <= 1'b1;
			rer <= 1'b0;
		end
		if (end_of_transfer_flag)
			eot_seen <= 1'b1;
		if (dev_command == 4'h5)
			jump_met <= take_jump;
		else if (io_command_code == 3'h2)
			jump_met <= 1'b0;
	end
	task wait_si(input v);
		begin
			@(posedge hclk);
			while (service_in !== v)
				@(posedge hclk);
		end
	endtask
	// Processor side: poll, then one service-out per poll
	initial forever begin : serve
		reg [2:0] c;
		reg [9:0] a;
		@(posedge hclk);
		if (hresetn && channel_service_request && !data_poll) begin
			data_poll <= 1'b1;
			wait_si(1'b1);
			c = io_command_code;
			// Table steps address the entry of the selected device
			a = (c == 3'h1 || c == 3'h4) ?
				{4'h0, dev_select, 2'b00} : io_data_out[9:0];
			if (c == 3'h3 && bank_extension_lines != 4'h0)
				bank_seen <= bank_extension_lines;
			io_data_in <= mem[a];
			if (c == 3'h1)
				mem[a] <= mem[a] + 16'h0002;
			if (c == 3'h4)
				mem[a] <= io_data_out + 16'h0002;
			service_out <= 1'b1;
			wait_si(1'b0);
			if (c == 3'h3) begin
				// Input data: the device itself answers, not the channel
				if (dev_command != 4'h9)
					wait_si(1'b1);
				mem[a] <= io_data_out;
				wr[a] <= 1'b1;
			end
			@(posedge hclk);
			service_out <= 1'b0;
			io_data_in <= ~io_data_in;
			@(posedge hclk);
			data_poll <= 1'b0;
			if (c == 3'h5) begin
				service_request[dev_select] <= 1'b0;
				dones = dones + 1;
			end
		end
	end
endmodule

/* File: tb/ios_seq_sva.sv */
`timescale 1ns/100ps
module ios_seq_sva #(
	parameter NDEV = 16
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Observed outputs and handshakes
	input wire hreadyout,
	input wire hresp,
	input wire data_poll,
	input wire service_out,
	input wire channel_service_request,
	input wire poll_out,
	input wire service_in,
	input wire [2:0] io_command_code,
	input wire io_data_oe_n,
	input wire [3:0] bank_extension_lines,
	input wire channel_service_out
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	chk_latch_clear: assert property (
		$fell(service_out) |=> !channel_service_request)
		else $error("request latch kept after service-out");
	chk_poll_block: assert property (
		service_in |-> !poll_out)
		else $error("poll passed on while serving");
	chk_grant_answer: assert property (
		$rose(data_poll) && channel_service_request
		|-> ##[1:6] (service_in || channel_service_out))
		else $error("no answer to poll");
	chk_fetch_drive: assert property (
		service_in && io_command_code == 3'h2 |-> !io_data_oe_n)
		else $error("address not driven on fetch");
	chk_store_drive: assert property (
		$rose(service_in) && !service_out && io_command_code == 3'h3
		|-> !io_data_oe_n)
		else $error("address not driven on store");
	chk_si_drops: assert property (
		$rose(service_out) |-> ##[1:3] !service_in)
		else $error("service-in kept after service-out");
	chk_end_release: assert property (
		$fell(service_out) |=> !service_in && io_data_oe_n)
		else $error("drives kept after service-out fall");
	chk_bank_zero: assert property (
		io_command_code == 3'h1 || io_command_code == 3'h4
		|-> bank_extension_lines == 4'h0)
		else $error("bank not zero on table step");
	chk_cso_pulse: assert property (
		channel_service_out |=> !channel_service_out)
		else $error("channel service-out longer than a cycle");
endmodule
bind ios_sequencer ios_seq_sva #(.NDEV(NDEV)) chk_u (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
	.hresp(hresp), .data_poll(data_poll), .service_out(service_out),
	.channel_service_request(channel_service_request),
	.poll_out(poll_out), .service_in(service_in),
	.io_command_code(io_command_code), .io_data_oe_n(io_data_oe_n),
	.bank_extension_lines(bank_extension_lines),
	.channel_service_out(channel_service_out)
);

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, s) begin \
	compares = compares + 1; \
	if ((s) !== (e)) begin \
		failures = failures + 1; \
		$display("unexpected %s exp %h got %h", n, e, s); \
	end \
end

module tb_top;
	reg hclk, hresetn, hwrite;
	reg [1:0] htrans;
	reg [31:0] haddr, hwdata, rd;
	wire [31:0] hrdata;
	wire hreadyout, hresp, data_poll, service_out, service_in, poll_out;
	wire channel_service_request, io_data_oe_n, end_of_transfer_flag;
	wire channel_service_out;
	wire [2:0] io_command_code;
	wire [15:0] io_data_in, io_data_out, service_request;
	wire [3:0] bank_extension_lines, dev_command, dev_select;
	integer failures, compares, n, k, k0, cso_n;
	reg dend;
	wire jump_met;
	ios_sequencer dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .data_poll(data_poll), .service_out(service_out),
		.io_data_in(io_data_in),
		.channel_service_request(channel_service_request),
		.poll_out(poll_out), .service_in(service_in),
		.io_command_code(io_command_code), .io_data_out(io_data_out),
		.io_data_oe_n(io_data_oe_n),
		.bank_extension_lines(bank_extension_lines),
		.service_request(service_request), .device_end(dend),
		.jump_met(jump_met), .dev_command(dev_command),
		.dev_select(dev_select),
		.end_of_transfer_flag(end_of_transfer_flag),
		.channel_service_out(channel_service_out)
	);
	ios_far_model far_u (
		.hclk(hclk), .hresetn(hresetn),
		.channel_service_request(channel_service_request),
		.service_in(service_in), .io_command_code(io_command_code),
		.io_data_out(io_data_out),
		.bank_extension_lines(bank_extension_lines),
		.dev_command(dev_command), .dev_select(dev_select),
		.end_of_transfer_flag(end_of_transfer_flag),
		.data_poll(data_poll), .service_out(service_out),
		.io_data_in(io_data_in), .service_request(service_request),
		.jump_met(jump_met)
	);
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk)
		if (channel_service_out === 1'b1)
			cso_n <= cso_n + 1;
	task ahb(input w, input [7:0] a, input [31:0] d);
		begin
			haddr <= {24'h000000, a};
			hwrite <= w;
			htrans <= 2'b10;
			@(posedge hclk);
			while (hreadyout !== 1'b1)
				@(posedge hclk);
			htrans <= 2'b00;
			hwdata <= d;
			@(posedge hclk);
			while (hreadyout !== 1'b1)
				@(posedge hclk);
			rd = hrdata;
		end
	endtask
	task run_prog(input [3:0] dev);
		begin
			n = far_u.dones;
			ahb(1'b1, 8'h04, {28'h0000000, dev});
			far_u.service_request[dev] <= 1'b1;
			k = 0;
			while (far_u.dones == n && k < 4000) begin
				@(posedge hclk);
				k = k + 1;
			end
			`CHK("halt", 1'b1, k < 4000)
		end
	endtask
	task t_regs;
		begin
			ahb(1'b0, 8'h00, 32'h0);
			`CHK("ctrl reset", 32'h00000000, rd)
			ahb(1'b0, 8'h0C, 32'h0);
			`CHK("bank reset", 32'h00000000, rd)
			ahb(1'b0, 8'h08, 32'h0);
			`CHK("status reset", 32'h00000600, rd)
			ahb(1'b1, 8'h0C, 32'h00000003);
			ahb(1'b1, 8'h10, 32'hFFFFFFFF);
			ahb(1'b0, 8'h10, 32'h0);
			`CHK("unmapped", 32'h00000000, rd)
			ahb(1'b1, 8'h00, 32'h00000001);
			ahb(1'b0, 8'h00, 32'h0);
			`CHK("ctrl", 32'h00000001, rd)
			ahb(1'b0, 8'h0C, 32'h0);
			`CHK("bank", 32'h00000003, rd)
			$display("test regs done");
		end
	endtask
	task t_residue;
		begin
			far_u.mem[8] = 16'h0100;
			far_u.mem[256] = 16'h1000;
			far_u.mem[258] = 16'h3000;
			run_prog(4'h2);
			`CHK("residue", 16'h1000, far_u.mem[257])
			`CHK("end store", 1'b1, far_u.wr[259])
			`CHK("table", 16'h0104, far_u.mem[8])
			$display("test residue done");
		end
	endtask
	task t_read;
		begin
			k0 = cso_n;
			far_u.mem[4] = 16'h0200;
			far_u.mem[512] = 16'h7FFE;
			far_u.mem[513] = 16'h0300;
			far_u.mem[514] = 16'h3000;
			run_prog(4'h1);
			`CHK("word 0", 1'b1, far_u.wr[768])
			`CHK("word 1", 1'b1, far_u.wr[769])
			`CHK("eot", 1'b1, far_u.eot_seen)
			`CHK("next cmd", 1'b1, far_u.wr[515])
			`CHK("data bank", 4'h3, far_u.bank_seen)
			`CHK("aw kept", 16'h0300, far_u.mem[513])
			`CHK("cso data", 2, cso_n - k0)
			$display("test read done");
		end
	endtask
	task t_jump;
		begin
			far_u.take_jump = 1'b1;
			far_u.mem[12] = 16'h0040;
			far_u.mem[64] = 16'h0800;
			far_u.mem[65] = 16'h0050;
			far_u.mem[80] = 16'h0000;
			far_u.mem[81] = 16'h0058;
			far_u.mem[88] = 16'h3000;
			run_prog(4'h3);
			`CHK("jump table", 16'h005A, far_u.mem[12])
			`CHK("jump target", 1'b1, far_u.wr[89])
			far_u.take_jump = 1'b0;
			$display("test jump done");
		end
	endtask
	task t_devend;
		begin
			k0 = cso_n;
			dend <= 1'b1;
			far_u.mem[16] = 16'h0060;
			far_u.mem[96] = 16'h6000;
			far_u.mem[97] = 16'h0070;
			far_u.mem[98] = 16'h3000;
			run_prog(4'h4);
			`CHK("dev end", 1'b1, far_u.wr[99])
			`CHK("cso pulses", 1, cso_n - k0)
			`CHK("dev table", 16'h0064, far_u.mem[16])
			dend <= 1'b0;
			$display("test devend done");
		end
	endtask
	task give_verdict;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		failures = 0;
		compares = 0;
		hresetn = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		dend = 1'b0;
		cso_n = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_residue;
		t_read;
		t_jump;
		t_devend;
		give_verdict;
	end
	initial begin
		#200000;
		failures = failures + 1;
		give_verdict;
	end
endmodule
